/* File: inc/rtr_pkg.sv */
package rtr_pkg;

	// Register addresses as seen from the configuration interface
	localparam logic [5:0] RTR_ADDR_CONVERTER_TEST   = 6'h2D;
	localparam logic [5:0] RTR_ADDR_DAC_SOURCE_TEST  = 6'h2E;
	localparam logic [5:0] RTR_ADDR_TOP_LEVEL_TEST   = 6'h2F;
	localparam logic [5:0] RTR_ADDR_SPARE_CONTROL    = 6'h30;
	localparam logic [5:0] RTR_ADDR_TRANSMIT_QUEUE   = 6'h3E;
	localparam logic [5:0] RTR_ADDR_RECEIVE_QUEUE    = 6'h3F;

	// converter_test fields
	localparam int RTR_ADC_CLOCK_OFF_BIT = 15;
	localparam int RTR_ADC_I_MSB         = 14;
	localparam int RTR_ADC_I_LSB         = 8;
	localparam int RTR_ADC_Q_MSB         = 6;
	localparam int RTR_ADC_Q_LSB         = 0;

	// dac_source_test fields
	localparam int RTR_TX_CONVERTER_SOURCE_SELECT_MSB       = 14;
	localparam int RTR_TX_CONVERTER_SOURCE_SELECT_LSB       = 12;
	localparam int RTR_DAC_I_OVR_MSB     = 11;
	localparam int RTR_DAC_I_OVR_LSB     = 6;
	localparam int RTR_DAC_Q_OVR_MSB     = 5;
	localparam int RTR_DAC_Q_OVR_LSB     = 0;

	// top_level_test fields
	localparam int RTR_SELFTEST_BIT      = 7;
	localparam int RTR_BATMON_BIT        = 6;
	localparam int RTR_VC_DIR_BIT        = 5;
	localparam int RTR_ATEST_PD_BIT      = 4;
	localparam int RTR_ATEST_FN_MSB      = 3;
	localparam int RTR_ATEST_FN_LSB      = 0;

	// Reset values
	localparam logic        RTR_RST_ADC_CLOCK_OFF = 1'h0;
	localparam logic [14:0] RTR_RST_DAC_SOURCE    = 15'h0000;
	localparam logic [7:0]  RTR_RST_TOP_LEVEL     = 8'h10;
	localparam logic [15:0] RTR_RST_SPARE         = 16'h0000;

	// TX converter source codes
	localparam logic [2:0] RTR_SRC_MODULATOR = 3'h0;
	localparam logic [2:0] RTR_SRC_OVERRIDE  = 3'h1;
	localparam logic [2:0] RTR_SRC_ADC_HIGH  = 3'h2;
	localparam logic [2:0] RTR_SRC_FILTERED  = 3'h3;
	localparam logic [2:0] RTR_SRC_NOISE     = 3'h4;
	localparam logic [2:0] RTR_SRC_ADC_LOW   = 3'h5;
	localparam logic [2:0] RTR_SRC_MAGNITUDE = 3'h6;
	localparam logic [2:0] RTR_SRC_HS_TEST   = 3'h7;

	// Analog test functions
	localparam logic [3:0] RTR_ATEST_VC_LOOP   = 4'h7;
	localparam int         RTR_ATEST_FN_COUNT  = 9;

endpackage

/* File: logic/rtr_register_bank.sv */
`timescale 1ns/1ps

module rtr_register_bank
	import rtr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        xosc_running,
	input  wire logic        adc_enable,
	input  wire logic [6:0]  adc_i_sample,
	input  wire logic [6:0]  adc_q_sample,
	output logic             adc_clock_run,
	input  wire logic [5:0]  modulator_i,
	input  wire logic [5:0]  modulator_q,
	input  wire logic [5:0]  filtered_i,
	input  wire logic [5:0]  filtered_q,
	input  wire logic [5:0]  crc_noise_i,
	input  wire logic [5:0]  crc_noise_q,
	input  wire logic [5:0]  magnitude_i,
	input  wire logic [5:0]  magnitude_q,
	input  wire logic [5:0]  hs_test_i,
	input  wire logic [5:0]  hs_test_q,
	output logic      [5:0]  dac_i,
	output logic      [5:0]  dac_q,
	output logic             memory_selftest_run,
	output logic             battery_monitor_test_output,
	output logic             analog_test_power_down,
	output logic      [3:0]  analog_test_function,
	output logic      [8:0]  analog_test_route,
	output logic             vc_node_output_en,
	output logic             vc_node_drive_en,
	output logic             transmit_queue_push,
	output logic      [7:0]  transmit_queue_byte,
	output logic             receive_queue_pop,
	input  wire logic [7:0]  receive_queue_byte,
	output logic             receive_queue_write,
	output logic      [7:0]  receive_queue_wdata
);

	logic        adc_clock_off;
	logic [14:0] dac_source;
	logic [7:0]  top_level;
	logic [15:0] spare_bits;
	logic [15:0] next_rdata;
	logic [5:0]  next_dac_i;
	logic [5:0]  next_dac_q;
	logic [2:0]  source_select;
	logic        atest_on;
	logic [3:0]  atest_fn;
	logic        wr_converter;
	logic        wr_dac;
	logic        wr_top;
	logic        wr_spare;
	logic        queue_ok;

	assign wr_converter = reg_write && reg_addr == RTR_ADDR_CONVERTER_TEST;
	assign wr_dac       = reg_write && reg_addr == RTR_ADDR_DAC_SOURCE_TEST;
	assign wr_top       = reg_write && reg_addr == RTR_ADDR_TOP_LEVEL_TEST;
	assign wr_spare     = reg_write && reg_addr == RTR_ADDR_SPARE_CONTROL;
	// Queue push, write and pop strobes and receive read data stay inert while the crystal is stopped
	assign queue_ok     = xosc_running;

	// Only the clock-gate bit is storable; sample fields are read-only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			adc_clock_off <= RTR_RST_ADC_CLOCK_OFF;
		end else if (wr_converter) begin
			adc_clock_off <= reg_wdata[RTR_ADC_CLOCK_OFF_BIT];
		end
	end

	// Bit 15 is reserved and dropped
	always_ff @(posedge clock) begin
		if (!rstn) begin
			dac_source <= RTR_RST_DAC_SOURCE;
		end else if (wr_dac) begin
			dac_source <= reg_wdata[14:0];
		end
	end

	// Reserved bits 15:8 are not stored
	always_ff @(posedge clock) begin
		if (!rstn) begin
			top_level <= RTR_RST_TOP_LEVEL;
		end else if (wr_top) begin
			top_level <= reg_wdata[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			spare_bits <= RTR_RST_SPARE;
		end else if (wr_spare) begin
			spare_bits <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			adc_clock_run <= 1'b0;
		end else begin
			adc_clock_run <= adc_enable && !adc_clock_off;
		end
	end

	// TX converter source selection
	assign source_select = dac_source[RTR_TX_CONVERTER_SOURCE_SELECT_MSB:RTR_TX_CONVERTER_SOURCE_SELECT_LSB];

	always_comb begin
		case (source_select)
			RTR_SRC_MODULATOR: begin
				next_dac_i = modulator_i;
				next_dac_q = modulator_q;
			end
			RTR_SRC_OVERRIDE: begin
				next_dac_i = dac_source[RTR_DAC_I_OVR_MSB:RTR_DAC_I_OVR_LSB];
				next_dac_q = dac_source[RTR_DAC_Q_OVR_MSB:RTR_DAC_Q_OVR_LSB];
			end
			RTR_SRC_ADC_HIGH: begin
				next_dac_i = adc_i_sample[6:1];
				next_dac_q = adc_q_sample[6:1];
			end
			RTR_SRC_FILTERED: begin
				next_dac_i = filtered_i;
				next_dac_q = filtered_q;
			end
			RTR_SRC_NOISE: begin
				next_dac_i = crc_noise_i;
				next_dac_q = crc_noise_q;
			end
			RTR_SRC_ADC_LOW: begin
				next_dac_i = adc_i_sample[5:0];
				next_dac_q = adc_q_sample[5:0];
			end
			RTR_SRC_MAGNITUDE: begin
				next_dac_i = magnitude_i;
				next_dac_q = magnitude_q;
			end
			RTR_SRC_HS_TEST: begin
				next_dac_i = hs_test_i;
				next_dac_q = hs_test_q;
			end
			default: begin
				next_dac_i = modulator_i;
				next_dac_q = modulator_q;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			dac_i <= 6'h00;
			dac_q <= 6'h00;
		end else begin
			dac_i <= next_dac_i;
			dac_q <= next_dac_q;
		end
	end

	// Top-level test controls
	assign atest_on = !top_level[RTR_ATEST_PD_BIT];
	assign atest_fn = top_level[RTR_ATEST_FN_MSB:RTR_ATEST_FN_LSB];

	always_ff @(posedge clock) begin
		if (!rstn) begin
			memory_selftest_run         <= 1'b0;
			battery_monitor_test_output <= 1'b0;
			analog_test_power_down      <= 1'b1;
			analog_test_function        <= 4'h0;
			vc_node_output_en           <= 1'b0;
			vc_node_drive_en            <= 1'b0;
		end else begin
			memory_selftest_run         <= top_level[RTR_SELFTEST_BIT];
			battery_monitor_test_output <= top_level[RTR_BATMON_BIT];
			analog_test_power_down      <= !atest_on;
			analog_test_function        <= atest_on ? atest_fn : 4'h0;
			vc_node_output_en           <= atest_on
				&& atest_fn == RTR_ATEST_VC_LOOP
				&& !top_level[RTR_VC_DIR_BIT];
			vc_node_drive_en            <= atest_on
				&& atest_fn == RTR_ATEST_VC_LOOP
				&& top_level[RTR_VC_DIR_BIT];
		end
	end

	// One route line per analog test function, all idle when powered down
	genvar fn;
	generate
		for (fn = 0; fn < RTR_ATEST_FN_COUNT; fn++) begin : g_route
			always_ff @(posedge clock) begin
				if (!rstn) begin
					analog_test_route[fn] <= 1'b0;
				end else begin
					analog_test_route[fn] <= atest_on
						&& atest_fn == 4'(fn);
				end
			end
		end
	endgenerate

	// Queue byte ports
	always_ff @(posedge clock) begin
		if (!rstn) begin
			transmit_queue_push <= 1'b0;
			transmit_queue_byte <= 8'h00;
		end else begin
			transmit_queue_push <= queue_ok && reg_write
				&& reg_addr == RTR_ADDR_TRANSMIT_QUEUE;
			if (reg_write && reg_addr == RTR_ADDR_TRANSMIT_QUEUE) begin
				transmit_queue_byte <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			receive_queue_write <= 1'b0;
			receive_queue_wdata <= 8'h00;
		end else begin
			receive_queue_write <= queue_ok && reg_write
				&& reg_addr == RTR_ADDR_RECEIVE_QUEUE;
			if (reg_write && reg_addr == RTR_ADDR_RECEIVE_QUEUE) begin
				receive_queue_wdata <= reg_wdata[7:0];
			end
		end
	end

	// The FIFO presents its next byte; a read takes it and pops
	assign receive_queue_pop = queue_ok && reg_read
		&& reg_addr == RTR_ADDR_RECEIVE_QUEUE;

	// Read multiplexer
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr)
			RTR_ADDR_CONVERTER_TEST: begin
				next_rdata[RTR_ADC_CLOCK_OFF_BIT] = adc_clock_off;
				next_rdata[RTR_ADC_I_MSB:RTR_ADC_I_LSB] = adc_i_sample;
				next_rdata[RTR_ADC_Q_MSB:RTR_ADC_Q_LSB] = adc_q_sample;
			end
			RTR_ADDR_DAC_SOURCE_TEST: begin
				next_rdata[14:0] = dac_source;
			end
			RTR_ADDR_TOP_LEVEL_TEST: begin
				next_rdata[7:0] = top_level;
			end
			RTR_ADDR_SPARE_CONTROL: begin
				next_rdata = spare_bits;
			end
			RTR_ADDR_RECEIVE_QUEUE: begin
				if (queue_ok) begin
					next_rdata[7:0] = receive_queue_byte;
				end
			end
			RTR_ADDR_TRANSMIT_QUEUE: begin
				next_rdata = 16'h0000;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			if (reg_read) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule // rtr_register_bank

/* File: bench/rtr_register_bank_chk.sv */
`timescale 1ns/1ps
module rtr_register_bank_chk
	import rtr_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [5:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        xosc_running,
	input wire logic        adc_enable,
	input wire logic [6:0]  adc_i_sample,
	input wire logic [6:0]  adc_q_sample,
	input wire logic        adc_clock_run,
	input wire logic        analog_test_power_down,
	input wire logic [3:0]  analog_test_function,
	input wire logic [8:0]  analog_test_route,
	input wire logic        vc_node_output_en,
	input wire logic        transmit_queue_push,
	input wire logic [7:0]  transmit_queue_byte,
	input wire logic        receive_queue_pop,
	input wire logic [7:0]  receive_queue_byte
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire rd_sample = reg_read && reg_addr == RTR_ADDR_CONVERTER_TEST;
	wire rd_rx = reg_read && reg_addr == RTR_ADDR_RECEIVE_QUEUE && xosc_running;
	wire wr_tx = reg_write && reg_addr == RTR_ADDR_TRANSMIT_QUEUE && xosc_running;
	logic gate_off;

	// Model of the clock-gate bit, built from the register writes alone
	always_ff @(posedge clock) begin
		if (!rstn) begin
			gate_off <= 1'b0;
		end else if (reg_write && reg_addr == RTR_ADDR_CONVERTER_TEST) begin
			gate_off <= reg_wdata[RTR_ADC_CLOCK_OFF_BIT];
		end
	end

	chk_read_answer: assert property (1'b1 |=> reg_rvalid == $past(reg_read))
		else $error("read answer timing wrong");
	chk_sample_read: assert property (rd_sample |=>
		reg_rdata[14:0] == {$past(adc_i_sample), 1'b0, $past(adc_q_sample)})
		else $error("converter sample readback wrong");
	chk_clock_gate: assert property ($past(rstn) |->
		adc_clock_run == ($past(adc_enable) && !$past(gate_off)))
		else $error("converter clock gating wrong");
	chk_tx_push: assert property (wr_tx |=> transmit_queue_push &&
		transmit_queue_byte == $past(reg_wdata[7:0]))
		else $error("transmit byte not pushed");
	chk_tx_noread: assert property (
		reg_read && reg_addr == RTR_ADDR_TRANSMIT_QUEUE |=> reg_rdata == 16'h0000)
		else $error("transmit port read back");
	chk_rx_pop: assert property (receive_queue_pop |-> rd_rx)
		else $error("stray receive pop");
	chk_rx_data: assert property (rd_rx |-> receive_queue_pop ##1
		reg_rdata == {8'h00, $past(receive_queue_byte)})
		else $error("receive byte readback wrong");
	chk_pd_quiet: assert property (analog_test_power_down |->
		analog_test_function == 4'h0 && analog_test_route == 9'h000)
		else $error("test module active while powered down");
	chk_vc_output: assert property (vc_node_output_en |->
		!analog_test_power_down && analog_test_function == RTR_ATEST_VC_LOOP)
		else $error("vc node output outside loop mode");
endmodule // rtr_register_bank_chk

bind rtr_register_bank rtr_register_bank_chk u_chk (
	.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .xosc_running(xosc_running),
	.adc_enable(adc_enable), .adc_i_sample(adc_i_sample),
	.adc_q_sample(adc_q_sample), .adc_clock_run(adc_clock_run),
	.analog_test_power_down(analog_test_power_down),
	.analog_test_function(analog_test_function),
	.analog_test_route(analog_test_route),
	.vc_node_output_en(vc_node_output_en),
	.transmit_queue_push(transmit_queue_push),
	.transmit_queue_byte(transmit_queue_byte),
	.receive_queue_pop(receive_queue_pop),
	.receive_queue_byte(receive_queue_byte)
);

/* File: bench/rtr_rx_source.sv */
`timescale 1ns/1ps
module rtr_rx_source (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       pop,
	output logic      [7:0] head
);
	// Head advances on each pop so consecutive reads see new bytes
	always_ff @(posedge clock) begin
		if (!rstn) begin
			head <= 8'hA1;
		end else if (pop) begin
			head <= head + 8'h01;
		end
	end
endmodule // rtr_rx_source

/* File: bench/radio_test_register_bank_tb_top.sv */
`timescale 1ns/1ps
module radio_test_register_bank_tb_top
	import rtr_pkg::*;
;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic [5:0]  reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        xosc_running = 1'b1;
	logic        adc_enable = 1'b1;
	logic [6:0]  adc_i = 7'h5A;
	logic [6:0]  adc_q = 7'h27;
	logic [5:0]  cand_i [8];
	logic [5:0]  cand_q [8];
	logic [15:0] e;
	int          bad_count = 0;
	int          comparisons = 0;
	wire  [15:0] reg_rdata;
	wire  [8:0]  route;
	wire  [7:0]  tx_byte, rx_byte, rx_wdata;
	wire  [5:0]  dac_i, dac_q;
	wire  [3:0]  func;
	wire         rvalid, clk_run, selftest, batmon, pd, vc_out, vc_drive;
	wire         tx_push, rx_pop, rx_write;

	always #2.5 clock = ~clock;

	rtr_register_bank u_rtr_register_bank (
		.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .reg_rvalid(rvalid),
		.xosc_running(xosc_running), .adc_enable(adc_enable),
		.adc_i_sample(adc_i), .adc_q_sample(adc_q), .adc_clock_run(clk_run),
		.modulator_i(cand_i[0]), .modulator_q(cand_q[0]),
		.filtered_i(cand_i[3]), .filtered_q(cand_q[3]),
		.crc_noise_i(cand_i[4]), .crc_noise_q(cand_q[4]),
		.magnitude_i(cand_i[6]), .magnitude_q(cand_q[6]),
		.hs_test_i(cand_i[7]), .hs_test_q(cand_q[7]),
		.dac_i(dac_i), .dac_q(dac_q), .memory_selftest_run(selftest),
		.battery_monitor_test_output(batmon), .analog_test_power_down(pd),
		.analog_test_function(func), .analog_test_route(route),
		.vc_node_output_en(vc_out), .vc_node_drive_en(vc_drive),
		.transmit_queue_push(tx_push), .transmit_queue_byte(tx_byte),
		.receive_queue_pop(rx_pop), .receive_queue_byte(rx_byte),
		.receive_queue_write(rx_write), .receive_queue_wdata(rx_wdata)
	);

	rtr_rx_source u_rtr_rx_source (
		.clock(clock), .rstn(rstn), .pop(rx_pop), .head(rx_byte)
	);

	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		@(negedge clock);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		check({15'h0000, rvalid}, 16'h0001);
		check(reg_rdata, exp);
	endtask

	initial begin
		for (int k = 0; k < 8; k++) begin
			cand_i[k] = 6'(k * 7 + 3);
			cand_q[k] = 6'(k * 5 + 9);
		end
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		check({15'h0000, pd}, 16'h0001);
		rd(RTR_ADDR_TOP_LEVEL_TEST, 16'h0010);
		rd(RTR_ADDR_DAC_SOURCE_TEST, 16'h0000);
		rd(RTR_ADDR_SPARE_CONTROL, 16'h0000);
		rd(RTR_ADDR_CONVERTER_TEST, {1'b0, adc_i, 1'b0, adc_q});
		wr(RTR_ADDR_CONVERTER_TEST, 16'hFF7F);
		@(negedge clock);
		check({15'h0000, clk_run}, 16'h0000);
		rd(RTR_ADDR_CONVERTER_TEST, {1'b1, adc_i, 1'b0, adc_q});
		wr(RTR_ADDR_CONVERTER_TEST, 16'h0000);
		@(negedge clock);
		check({15'h0000, clk_run}, 16'h0001);
		adc_enable = 1'b0;
		@(negedge clock);
		check({15'h0000, clk_run}, 16'h0000);
		wr(RTR_ADDR_SPARE_CONTROL, 16'hA5C3);
		rd(RTR_ADDR_SPARE_CONTROL, 16'hA5C3);
		wr(6'h31, 16'hFFFF);
		rd(6'h31, 16'h0000);
		for (int m = 0; m < 10; m++) begin
			wr(RTR_ADDR_TOP_LEVEL_TEST, 16'(m));
			@(negedge clock);
			check({12'h000, func}, 16'(m));
			check({7'h00, route}, m < 9 ? 16'(1 << m) : 16'h0000);
		end
		wr(RTR_ADDR_TOP_LEVEL_TEST, 16'h00E7);
		@(negedge clock);
		check({12'h000, selftest, batmon, vc_out, vc_drive}, 16'h000D);
		wr(RTR_ADDR_TOP_LEVEL_TEST, 16'h0007);
		@(negedge clock);
		check({12'h000, selftest, batmon, vc_out, vc_drive}, 16'h0002);
		wr(RTR_ADDR_TOP_LEVEL_TEST, 16'h0017);
		@(negedge clock);
		check({2'h0, pd, func, route}, 16'h2000);
		rd(RTR_ADDR_TOP_LEVEL_TEST, 16'h0017);
		wr(RTR_ADDR_TOP_LEVEL_TEST, 16'h0004);
		// Override fields hold values that no other source carries
		for (int s = 0; s < 8; s++) begin
			wr(RTR_ADDR_DAC_SOURCE_TEST, {1'b0, 3'(s), cand_i[1], cand_q[1]});
			@(negedge clock);
			e = {4'h0, cand_i[s], cand_q[s]};
			if (s == 2) e = {4'h0, adc_i[6:1], adc_q[6:1]};
			if (s == 5) e = {4'h0, adc_i[5:0], adc_q[5:0]};
			check({4'h0, dac_i, dac_q}, e);
		end
		rd(RTR_ADDR_DAC_SOURCE_TEST, {4'h7, cand_i[1], cand_q[1]});
		wr(RTR_ADDR_TRANSMIT_QUEUE, 16'h00AB);
		check({7'h00, tx_push, tx_byte}, 16'h01AB);
		rd(RTR_ADDR_TRANSMIT_QUEUE, 16'h0000);
		rd(RTR_ADDR_RECEIVE_QUEUE, 16'h00A1);
		rd(RTR_ADDR_RECEIVE_QUEUE, 16'h00A2);
		wr(RTR_ADDR_RECEIVE_QUEUE, 16'h005A);
		check({7'h00, rx_write, rx_wdata}, 16'h015A);
		xosc_running = 1'b0;
		wr(RTR_ADDR_TRANSMIT_QUEUE, 16'h0033);
		check({15'h0000, tx_push}, 16'h0000);
		rd(RTR_ADDR_RECEIVE_QUEUE, 16'h0000);
		test_done;
	end

	initial begin
		#5000;
		bad_count++;
		test_done;
	end
endmodule // radio_test_register_bank_tb_top
